// ==== pm_pkg.sv ====
// pm_pkg: constants, register indexes and carrier types of the receive
// performance-monitoring status bank.
// assumes a 10 MHz core clock and 32-bit APB with one register per word.
package pm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_COUNTER_OVERFLOW_LATCH       = 8'h16;
   localparam logic [7:0] IDX_FRAME_SYNC_LOSS_COUNT        = 8'h17;
   localparam logic [7:0] IDX_ALIGNMENT_BIT_ERROR_COUNT    = 8'h18;
   localparam logic [7:0] IDX_REMOTE_ALARM_CRC_WORD        = 8'h19;
   localparam logic [7:0] IDX_ERRORED_ALIGNMENT_WORD_COUNT = 8'h1a;
   localparam logic [7:0] IDX_ALARM_LATCH                  = 8'h1b;
   localparam logic [7:0] IDX_LINE_CODE_VIOLATION_HIGH     = 8'h1c;
   localparam logic [7:0] IDX_LINE_CODE_VIOLATION_LOW      = 8'h1d;

   ////////////////////////////////////////////////////////////////////////////
   // bit positions in the overflow latch
   localparam int OVF_PSEUDO_RANDOM   = 7;
   localparam int OVF_FAR_END         = 6;
   localparam int OVF_JITTER_FIFO     = 5;
   localparam int OVF_SYNC_LOSS       = 4;
   localparam int OVF_ALIGNMENT_ERROR = 3;
   localparam int OVF_ERRORED_ALIGN   = 2;
   localparam int OVF_LINE_CODE       = 1;
   localparam int OVF_CRC4            = 0;

   // bit positions in the alarm latch; bit 0 unused
   localparam int ALM_REMOTE          = 7;
   localparam int ALM_ALL_ONES        = 6;
   localparam int ALM_SLOT16_ALL_ONES = 5;
   localparam int ALM_SIGNAL_LOSS     = 4;
   localparam int ALM_AUX_PATTERN     = 3;
   localparam int ALM_MULTIFRAME      = 2;
   localparam int ALM_BUFFER_SLIP     = 1;

   // bit positions in the remote alarm crc word
   localparam int RAC_WINDOWED   = 1;
   localparam int RAC_PERSISTENT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // timing: remote alarm with crc error persistence window
   localparam longint CLK_HZ          = 10_000_000;
   localparam longint RAC_MIN_MS      = 10;
   localparam longint RAC_MAX_MS      = 450;
   // least time rounds up, longest time rounds down
   localparam longint RAC_MIN_CYCLES  = (RAC_MIN_MS * CLK_HZ + 999) / 1000;
   localparam longint RAC_MAX_CYCLES  = (RAC_MAX_MS * CLK_HZ) / 1000;
   localparam int     RAC_CNT_W       = 23;

   ////////////////////////////////////////////////////////////////////////////
   // receive path events, one struct so the framer hooks up in one piece
   typedef struct packed {
      logic       pseudo_random_error_overflow; // pulse from prbs counter
      logic       far_end_error_overflow;       // pulse from e-bit counter
      logic       jitter_fifo_count_overflow;   // pulse from jitter fifo counter
      logic       crc4_error_overflow;          // pulse from crc-4 counter
      logic       frame_tick;                   // one pulse per 125 us frame
      logic       basic_sync_lost;              // level, basic frame sync absent
      logic       fas_word_valid;               // pulse, alignment word checked
      logic [2:0] fas_bit_errors;               // errored bits in that word
      logic       rai_crc_condition;            // level, a bits high and e bits low
      logic       remote_alarm;                 // a bit equals one
      logic       all_ones_alarm;
      logic       signalling_slot_all_ones_alarm;
      logic       signal_loss;
      logic       auxiliary_pattern_alarm;
      logic       multiframe_alarm;
      logic       receive_buffer_slip;
      logic       line_code_violation;          // pulse per bipolar violation
   } pm_rx_events_s;

endpackage

// ==== pm_status_bank.sv ====
// pm_status_bank: receive performance-monitoring counters and latches,
// read by software over APB.
// assumes event inputs synchronous to core_clk and one pulse per event.
//
// How it works
// RULE1: overflow latch bit 7 sets on prbs counter overflow, clears on read
// RULE2: overflow latch bit 6 sets on e-bit counter overflow, clears on read
// RULE3: overflow latch bit 5 sets on jitter fifo counter overflow, read clears
// RULE4: overflow latch bit 4 sets on sync loss counter overflow, read clears
// RULE5: overflow latch bit 3 sets on alignment bit error overflow, read clears
// RULE6: overflow latch bit 2 sets on errored alignment overflow, read clears
// RULE7: overflow latch bit 1 sets on 16-bit violation counter overflow
// RULE8: overflow latch bit 0 sets on crc-4 counter overflow, read clears
// RULE9: sync loss counter counts frames spent without basic frame sync
// RULE10: sync loss counter clears when basic sync is lost
// RULE11: alignment bit error counter sums bit errors in alignment words
// RULE12: windowed bit sets after condition lasted 10 to 450 ms, read clears
// RULE13: persistent bit high while condition has lasted over 10 ms
// RULE14: errored alignment counter counts alignment words with any error
// RULE15: alarm latch bit 7 sets on remote alarm, read clears
// RULE16: alarm latch bit 6 sets on all-ones alarm, read clears
// RULE17: alarm latch bit 5 sets on all ones in slot 16, read clears
// RULE18: alarm latch bit 4 sets on loss of signal, read clears
// RULE19: alarm latch bit 3 sets on auxiliary pattern, read clears
// RULE20: alarm latch bit 2 sets on multiframe alarm, read clears
// RULE21: alarm latch bit 1 sets on receive slip, read clears; bit 0 unused
// RULE22: 16-bit violation counter, high byte at one index, low at next
//
// The APB register port was chosen for this implementation.
module pm_status_bank
   import pm_pkg::*;
#(
   parameter int     ADDR_W         = 8,
   parameter longint RAC_MIN_CYC    = pm_pkg::RAC_MIN_CYCLES,
   parameter longint RAC_MAX_CYC    = pm_pkg::RAC_MAX_CYCLES
)
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // receive path events
   input  wire pm_pkg::pm_rx_events_s rx_events
);
   import pm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("pm_status_bank: ADDR_W must be 8 to 32");
   end
   if (RAC_MIN_CYC < 1 || RAC_MAX_CYC <= RAC_MIN_CYC)
   begin : g_bad_window
      $error("pm_status_bank: persistence window bounds invalid");
   end
   if (RAC_MAX_CYC >= (longint'(1) << RAC_CNT_W))
   begin : g_bad_counter
      $error("pm_status_bank: persistence window exceeds counter");
   end

   localparam logic [RAC_CNT_W-1:0] MIN_CYC = RAC_CNT_W'(RAC_MIN_CYC);
   localparam logic [RAC_CNT_W-1:0] MAX_CYC = RAC_CNT_W'(RAC_MAX_CYC);
   localparam logic [RAC_CNT_W-1:0] RAC_SAT = {RAC_CNT_W{1'b1}};

   // add with carry out; carry marks a counter overflow
   function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b);
      add8 = {1'b0, a} + {1'b0, b};
   endfunction

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = ADDR_W'({idx, 2'b00});
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]           counter_overflow_latch;
   logic [7:0]           frame_sync_loss_count;
   logic [7:0]           alignment_bit_error_count;
   logic [7:0]           errored_alignment_word_count;
   logic [7:0]           alarm_latch;
   logic [15:0]          line_code_violation_count;
   logic                 remote_alarm_crc_windowed;
   logic                 remote_alarm_crc_persistent;
   logic [RAC_CNT_W-1:0] rac_run;
   logic                 sync_lost_d;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire               setup_ok  = psel & penable & ~pready;
   // read-clear acts where prdata is captured, so no later event is wiped unseen
   wire               rd_take   = setup_ok & ~pwrite;
   wire [ADDR_W-1:0]  addr      = paddr;
   wire               hit_ovf   = addr == reg_addr(IDX_COUNTER_OVERFLOW_LATCH);
   wire               hit_lbf   = addr == reg_addr(IDX_FRAME_SYNC_LOSS_COUNT);
   wire               hit_ber   = addr == reg_addr(IDX_ALIGNMENT_BIT_ERROR_COUNT);
   wire               hit_rac   = addr == reg_addr(IDX_REMOTE_ALARM_CRC_WORD);
   wire               hit_efa   = addr == reg_addr(IDX_ERRORED_ALIGNMENT_WORD_COUNT);
   wire               hit_alm   = addr == reg_addr(IDX_ALARM_LATCH);
   wire               hit_lch   = addr == reg_addr(IDX_LINE_CODE_VIOLATION_HIGH);
   wire               hit_lcl   = addr == reg_addr(IDX_LINE_CODE_VIOLATION_LOW);
   wire               hit_any   = hit_ovf | hit_lbf | hit_ber | hit_rac |
                                  hit_efa | hit_alm | hit_lch | hit_lcl;
   wire               clr_ovf   = rd_take & hit_ovf;
   wire               clr_alm   = rd_take & hit_alm;
   wire               clr_rac   = rd_take & hit_rac;

   // read mux, if/else chain; unmapped reads return zero
   logic [7:0] rd_byte;
   always_comb
   begin
      if (hit_ovf)
         rd_byte = counter_overflow_latch;
      else if (hit_lbf)
         rd_byte = frame_sync_loss_count;
      else if (hit_ber)
         rd_byte = alignment_bit_error_count;
      else if (hit_rac)
         rd_byte = {6'h00, remote_alarm_crc_windowed, remote_alarm_crc_persistent};
      else if (hit_efa)
         rd_byte = errored_alignment_word_count;
      else if (hit_alm)
         rd_byte = alarm_latch;
      else if (hit_lch)
         rd_byte = line_code_violation_count[15:8]; // RULE22
      else if (hit_lcl)
         rd_byte = line_code_violation_count[7:0]; // RULE22
      else
         rd_byte = RESET_BYTE;
   end

   // one wait state: data and ready come from flops in the same edge
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup_ok;
         prdata  <= (setup_ok & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         pslverr <= setup_ok & ~hit_any;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sync loss counter
   wire       sync_loss_edge = rx_events.basic_sync_lost & ~sync_lost_d;
   wire       lbf_step       = rx_events.basic_sync_lost & rx_events.frame_tick;
   wire [8:0] lbf_sum        = add8(frame_sync_loss_count, 8'h01);
   wire       lbf_ovf        = lbf_step & ~sync_loss_edge & lbf_sum[8];
   logic [7:0] next_lbf;
   always_comb
   begin
      if (sync_loss_edge)
         next_lbf = RESET_BYTE; // RULE10
      else if (lbf_step)
         next_lbf = lbf_sum[7:0]; // RULE9
      else
         next_lbf = frame_sync_loss_count;
   end

   // alignment word counters
   wire [8:0] ber_sum = add8(alignment_bit_error_count, {5'h00, rx_events.fas_bit_errors});
   wire [8:0] efa_sum = add8(errored_alignment_word_count, 8'h01);
   wire       fas_err = rx_events.fas_word_valid & (rx_events.fas_bit_errors != 3'h0);
   wire       ber_ovf = rx_events.fas_word_valid & ber_sum[8];
   wire       efa_ovf = fas_err & efa_sum[8];

   // 16-bit line code violation counter
   wire [16:0] lcv_sum = {1'b0, line_code_violation_count} + 17'h0_0001;
   wire        lcv_ovf = rx_events.line_code_violation & lcv_sum[16];

   ////////////////////////////////////////////////////////////////////////////
   // latch set terms; a set in the cycle of a clearing read wins
   wire [7:0] ovf_set;
   assign ovf_set[OVF_PSEUDO_RANDOM]   = rx_events.pseudo_random_error_overflow; // RULE1
   assign ovf_set[OVF_FAR_END]         = rx_events.far_end_error_overflow;       // RULE2
   assign ovf_set[OVF_JITTER_FIFO]     = rx_events.jitter_fifo_count_overflow;   // RULE3
   assign ovf_set[OVF_SYNC_LOSS]       = lbf_ovf;                                // RULE4
   assign ovf_set[OVF_ALIGNMENT_ERROR] = ber_ovf;                                // RULE5
   assign ovf_set[OVF_ERRORED_ALIGN]   = efa_ovf;                                // RULE6
   assign ovf_set[OVF_LINE_CODE]       = lcv_ovf;                                // RULE7
   assign ovf_set[OVF_CRC4]            = rx_events.crc4_error_overflow;          // RULE8

   wire [7:0] alm_set;
   assign alm_set[ALM_REMOTE]          = rx_events.remote_alarm;                   // RULE15
   assign alm_set[ALM_ALL_ONES]        = rx_events.all_ones_alarm;                 // RULE16
   assign alm_set[ALM_SLOT16_ALL_ONES] = rx_events.signalling_slot_all_ones_alarm; // RULE17
   assign alm_set[ALM_SIGNAL_LOSS]     = rx_events.signal_loss;                    // RULE18
   assign alm_set[ALM_AUX_PATTERN]     = rx_events.auxiliary_pattern_alarm;        // RULE19
   assign alm_set[ALM_MULTIFRAME]      = rx_events.multiframe_alarm;               // RULE20
   assign alm_set[ALM_BUFFER_SLIP]     = rx_events.receive_buffer_slip;            // RULE21
   assign alm_set[0]                   = 1'b0;                                     // RULE21

   wire [7:0] next_ovf = (counter_overflow_latch & ~{8{clr_ovf}}) | ovf_set;
   wire [7:0] next_alm = (alarm_latch & ~{8{clr_alm}}) | alm_set;

   ////////////////////////////////////////////////////////////////////////////
   // remote alarm with crc error persistence; run length saturates
   wire       rac_cond      = rx_events.rai_crc_condition;
   wire [RAC_CNT_W-1:0] next_rac_run =
      !rac_cond ? '0 : (rac_run == RAC_SAT) ? rac_run : rac_run + 1'b1;
   // a run that ends inside the window is reported once it ends
   wire       rac_in_window = ~rac_cond & (rac_run > MIN_CYC) & (rac_run < MAX_CYC);
   wire       next_windowed = (remote_alarm_crc_windowed & ~clr_rac) | rac_in_window;
   wire       next_persist  = rac_cond & (rac_run >= MIN_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // latches
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         counter_overflow_latch <= RESET_BYTE;
         alarm_latch            <= RESET_BYTE;
      end
      else
      begin
         counter_overflow_latch <= next_ovf; // RULE1 RULE8
         alarm_latch            <= next_alm; // RULE15 RULE21
      end
   end

   // counters
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         frame_sync_loss_count        <= RESET_BYTE;
         alignment_bit_error_count    <= RESET_BYTE;
         errored_alignment_word_count <= RESET_BYTE;
         line_code_violation_count    <= RESET_WORD;
         sync_lost_d                  <= 1'b0;
      end
      else
      begin
         frame_sync_loss_count <= next_lbf;
         if (rx_events.fas_word_valid)
            alignment_bit_error_count <= ber_sum[7:0]; // RULE11
         if (fas_err)
            errored_alignment_word_count <= efa_sum[7:0]; // RULE14
         if (rx_events.line_code_violation)
            line_code_violation_count <= lcv_sum[15:0]; // RULE22
         sync_lost_d <= rx_events.basic_sync_lost;
      end
   end

   // persistence timer and its two status bits
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rac_run                     <= '0;
         remote_alarm_crc_windowed   <= 1'b0;
         remote_alarm_crc_persistent <= 1'b0;
      end
      else
      begin
         rac_run                     <= next_rac_run;
         remote_alarm_crc_windowed   <= next_windowed; // RULE12
         remote_alarm_crc_persistent <= next_persist;  // RULE13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access_wait;
      psel && penable && !pready;
   endsequence

   chk_apb_one_wait: assert property (s_setup ##1 s_access_wait |=> pready ##1 !pready)
      else $error("apb answer not after one wait state");

   chk_ovf_bpv_wrap: assert property ( // RULE7
      rx_events.line_code_violation && line_code_violation_count == 16'hffff
      |=> counter_overflow_latch[OVF_LINE_CODE] && line_code_violation_count == 16'h0000)
      else $error("violation counter wrap did not set overflow bit");

   chk_ovf_read_clear: assert property ( // RULE1
      clr_ovf && ovf_set == 8'h00 |=> counter_overflow_latch == 8'h00)
      else $error("overflow latch not cleared by read");

   chk_ovf_set_wins: assert property ( // RULE8
      clr_ovf && rx_events.crc4_error_overflow |=> counter_overflow_latch[OVF_CRC4])
      else $error("overflow set lost during clearing read");

   chk_lbf_clear_edge: assert property ( // RULE10
      $rose(rx_events.basic_sync_lost) |=> frame_sync_loss_count == 8'h00)
      else $error("sync loss counter not cleared on loss");

   chk_lbf_frame_count: assert property ( // RULE9
      lbf_step && !sync_loss_edge
      |=> frame_sync_loss_count == 8'($past(frame_sync_loss_count) + 8'h01))
      else $error("sync loss counter did not step per frame");

   chk_ber_sum: assert property ( // RULE11
      rx_events.fas_word_valid
      |=> alignment_bit_error_count ==
          8'($past(alignment_bit_error_count) + {5'h00, $past(rx_events.fas_bit_errors)}))
      else $error("alignment bit errors not accumulated");

   chk_efa_count: assert property ( // RULE14
      rx_events.fas_word_valid && rx_events.fas_bit_errors == 3'h0
      |=> $stable(errored_alignment_word_count))
      else $error("clean alignment word counted as errored");

   chk_rac_persist: assert property ( // RULE13
      !rac_cond |=> !remote_alarm_crc_persistent)
      else $error("persistent bit high without condition");

   chk_rac_window: assert property ( // RULE12
      $fell(rac_cond) && rac_run > MIN_CYC && rac_run < MAX_CYC
      |=> remote_alarm_crc_windowed)
      else $error("windowed bit not set for in-window run");

   chk_alarm_slip: assert property ( // RULE21
      rx_events.receive_buffer_slip |=> alarm_latch[ALM_BUFFER_SLIP] && !alarm_latch[0])
      else $error("slip not latched or unused bit set");

   chk_alarm_clear: assert property ( // RULE15
      clr_alm && alm_set == 8'h00 |=> alarm_latch == 8'h00)
      else $error("alarm latch not cleared by read");

   chk_ovf_set_any: assert property ( // RULE2
      ovf_set != 8'h00 |=> (counter_overflow_latch & $past(ovf_set)) == $past(ovf_set))
      else $error("overflow event not latched");

   chk_lbf_wrap: assert property ( // RULE4
      lbf_step && !sync_loss_edge && frame_sync_loss_count == 8'hff
      |=> counter_overflow_latch[OVF_SYNC_LOSS] && frame_sync_loss_count == 8'h00)
      else $error("sync loss counter wrap did not set overflow bit");

   chk_ber_wrap: assert property ( // RULE5
      rx_events.fas_word_valid &&
      ({1'b0, alignment_bit_error_count} + {6'h00, rx_events.fas_bit_errors}) > 9'h0ff
      |=> counter_overflow_latch[OVF_ALIGNMENT_ERROR])
      else $error("bit error counter wrap did not set overflow bit");

   chk_efa_step: assert property ( // RULE14
      rx_events.fas_word_valid && rx_events.fas_bit_errors != 3'h0
      |=> errored_alignment_word_count == 8'($past(errored_alignment_word_count) + 8'h01))
      else $error("errored word not counted");

   chk_efa_wrap: assert property ( // RULE6
      fas_err && errored_alignment_word_count == 8'hff
      |=> counter_overflow_latch[OVF_ERRORED_ALIGN])
      else $error("errored word counter wrap did not set overflow bit");

   chk_lcv_step: assert property ( // RULE22
      rx_events.line_code_violation
      |=> line_code_violation_count == 16'($past(line_code_violation_count) + 16'h0001))
      else $error("violation counter did not step");

   chk_alarm_set: assert property ( // RULE16
      alm_set != 8'h00 |=> (alarm_latch & $past(alm_set)) == $past(alm_set))
      else $error("alarm event not latched");

   sequence s_rac_held;
      rac_cond && rac_run >= MIN_CYC;
   endsequence
   chk_rac_held: assert property ( // RULE13
      s_rac_held ##1 rac_cond |-> remote_alarm_crc_persistent)
      else $error("persistent bit low during long run");

endmodule

// ==== pm_status_bank_tb.sv ====
// pm_status_bank_tb: self-checking bench for the receive status bank.
// assumes pm_pkg compiled first; drives apb and rx_events itself.
module pm_status_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // clock, reset, bus and event stimulus
   logic          core_clk;
   logic          arst_n;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [7:0]    paddr;
   logic [31:0]   pwdata;
   logic          pready;
   logic [31:0]   prdata;
   logic          pslverr;
   pm_rx_events_s ev;
   logic [32:0]   exp_q[$];
   logic [32:0]   exp_now;
   int            error_cnt;
   int            n_tests;
   int            cyc;
   integer        seed;
   logic [31:0]   r;
   logic [15:0]   lcv;
   logic [7:0]    sync_cnt;
   logic [7:0]    ber;
   logic [7:0]    efw;
   logic [7:0]    ovf;
   logic          c;

   // short persistence window keeps the run small
   pm_status_bank #(.ADDR_W(8), .RAC_MIN_CYC(20), .RAC_MAX_CYC(200)) DUT (
      .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .rx_events(ev));

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparison and closing report
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // monitor: every completed transfer pops the oldest expectation
   always @(posedge core_clk)
   begin
      if (pready === 1'b1)
      begin
         exp_now = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_dead_beef;
         check({pslverr, prdata}, exp_now);
      end
   end

   // hang guard, well above the longest sequence
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb master: setup, access held until pready sampled high, then release
   task automatic apb(input logic w, input logic [7:0] idx, input logic [32:0] exp);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx[5:0], 2'b00};
      pwdata  <= $random(seed);
      exp_q.push_back(exp);
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] b);
      apb(1'b0, idx, {9'h000, 16'h0000, b});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // alarm sources in latch order, bit 7 down to bit 1, one cycle high
   task automatic pulse_alarms(input logic [6:0] a);
      @(posedge core_clk);
      {ev.remote_alarm, ev.all_ones_alarm, ev.signalling_slot_all_ones_alarm,
       ev.signal_loss, ev.auxiliary_pattern_alarm, ev.multiframe_alarm,
       ev.receive_buffer_slip} <= a;
      @(posedge core_clk);
      {ev.remote_alarm, ev.all_ones_alarm, ev.signalling_slot_all_ones_alarm,
       ev.signal_loss, ev.auxiliary_pattern_alarm, ev.multiframe_alarm,
       ev.receive_buffer_slip} <= 7'h00;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      seed = 32'h7b6e;
      {error_cnt, n_tests, cyc} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ev = '0;
      arst_n = 1'b0;
      idle(20);
      arst_n <= 1'b1;
      // reset values of every register, then a refused address
      for (int i = 8'h16; i <= 8'h1d; i++) rd(8'(i), RESET_BYTE);
      apb(1'b0, 8'h20, {1'b1, 32'h0000_0000});
      apb(1'b1, 8'h20, {1'b1, 32'h0000_0000});
      apb(1'b1, IDX_ALARM_LATCH, 33'h0); // writes have no effect
      // overflow pulses from the outside counters, then read clears
      @(posedge core_clk);
      {ev.pseudo_random_error_overflow, ev.far_end_error_overflow,
       ev.jitter_fifo_count_overflow, ev.crc4_error_overflow} <= 4'hf;
      @(posedge core_clk);
      {ev.pseudo_random_error_overflow, ev.far_end_error_overflow,
       ev.jitter_fifo_count_overflow, ev.crc4_error_overflow} <= 4'h0;
      rd(IDX_COUNTER_OVERFLOW_LATCH, 8'he1);
      rd(IDX_COUNTER_OVERFLOW_LATCH, 8'h00);
      // each alarm alone, then a random mix; bit 0 never set
      for (int b = 0; b < 7; b++)
      begin
         pulse_alarms(7'h01 << b);
         rd(IDX_ALARM_LATCH, 8'h02 << b);
      end
      r = $random(seed);
      pulse_alarms(r[6:0]);
      rd(IDX_ALARM_LATCH, {r[6:0], 1'b0});
      rd(IDX_ALARM_LATCH, 8'h00);
      // counters driven past their wrap points with random traffic
      @(posedge core_clk);
      ev.basic_sync_lost <= 1'b1;
      {lcv, sync_cnt, ber, efw, ovf} = '0;
      for (int i = 0; i < 65540; i++)
      begin
         @(posedge core_clk);
         r = $random(seed);
         ev.line_code_violation <= 1'b1;
         ev.frame_tick <= r[0];
         ev.fas_word_valid <= r[1];
         ev.fas_bit_errors <= r[4:2];
         {c, lcv} = lcv + 17'd1;
         ovf[OVF_LINE_CODE] |= c;
         {c, sync_cnt} = sync_cnt + {8'h00, r[0]};
         ovf[OVF_SYNC_LOSS] |= c;
         {c, ber} = ber + (r[1] ? {5'h00, r[4:2]} : 8'h00);
         ovf[OVF_ALIGNMENT_ERROR] |= c;
         {c, efw} = efw + {8'h00, r[1] & (r[4:2] != 3'h0)};
         ovf[OVF_ERRORED_ALIGN] |= c;
      end
      @(posedge core_clk);
      {ev.line_code_violation, ev.frame_tick, ev.fas_word_valid} <= 3'h0;
      rd(IDX_COUNTER_OVERFLOW_LATCH, ovf);
      rd(IDX_FRAME_SYNC_LOSS_COUNT, sync_cnt);
      rd(IDX_ALIGNMENT_BIT_ERROR_COUNT, ber);
      rd(IDX_ERRORED_ALIGNMENT_WORD_COUNT, efw);
      rd(IDX_LINE_CODE_VIOLATION_HIGH, lcv[15:8]);
      rd(IDX_LINE_CODE_VIOLATION_LOW, lcv[7:0]);
      rd(IDX_COUNTER_OVERFLOW_LATCH, 8'h00);
      // regaining then losing sync empties the frame counter
      @(posedge core_clk);
      ev.basic_sync_lost <= 1'b0;
      idle(3);
      ev.basic_sync_lost <= 1'b1;
      rd(IDX_FRAME_SYNC_LOSS_COUNT, 8'h00);
      // condition inside the window: persistent while held, windowed after
      @(posedge core_clk);
      ev.rai_crc_condition <= 1'b1;
      idle(60);
      rd(IDX_REMOTE_ALARM_CRC_WORD, 8'h01);
      @(posedge core_clk);
      ev.rai_crc_condition <= 1'b0;
      idle(5);
      rd(IDX_REMOTE_ALARM_CRC_WORD, 8'h02);
      rd(IDX_REMOTE_ALARM_CRC_WORD, 8'h00);
      // too short a run, then too long a run: neither sets the windowed bit
      ev.rai_crc_condition <= 1'b1;
      idle(10);
      ev.rai_crc_condition <= 1'b0;
      idle(3);
      ev.rai_crc_condition <= 1'b1;
      idle(260);
      ev.rai_crc_condition <= 1'b0;
      idle(5);
      rd(IDX_REMOTE_ALARM_CRC_WORD, 8'h00);
      idle(5);
      give_verdict();
   end
endmodule
